// File: src/ccc_map.svh
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

// Register byte offsets on the register bus.
`define CCC_OFF_CLOCK_CONFIG 8'h00
`define CCC_OFF_CLOCK_CAL 8'h04
`define CCC_OFF_PAD_CONFIG 8'h08
`define CCC_OFF_ALARM_CONFIG 8'h0C
`define CCC_OFF_ALARM_REPEAT 8'h10
`define CCC_OFF_VALUE_HIGH 8'h14
`define CCC_OFF_VALUE_LOW 8'h18
`define CCC_OFF_ALARM_HIGH 8'h1C
`define CCC_OFF_ALARM_LOW 8'h20
`define CCC_OFF_UNLOCK_KEY 8'h24
`define CCC_OFF_IRQ_FLAGS 8'h28
`define CCC_OFF_IRQ_ENABLES 8'h2C
`define CCC_OFF_IRQ_PRIO 8'h30

// Field positions in the clock configuration and interrupt registers.
`define CCC_CFG_RUN 7
`define CCC_CFG_WREN 5
`define CCC_CFG_SYNC 4
`define CCC_CFG_HALF 3
`define CCC_CFG_OE 2
`define CCC_IRQ_CAL 0

// Pointer codes and unlock keys.
`define CCC_PTR_MINUTES_SECONDS_REG 2'h0
`define CCC_PTR_WDHR 2'h1
`define CCC_PTR_MONDAY 2'h2
`define CCC_PTR_YEAR 2'h3
`define CCC_KEY_FIRST 8'h55
`define CCC_KEY_SECOND 8'hAA

// Reset values.
`define CCC_RST_BYTE 8'h00
`define CCC_RST_DAY 8'h01
`define CCC_RST_MONTH 8'h01

// Calendar limits in BCD.
`define CCC_MAX_SEC 8'h59
`define CCC_MAX_HOUR 8'h23
`define CCC_MAX_WDAY 8'h06
`define CCC_MAX_MONTH 8'h12
`define CCC_MAX_YEAR 8'h99
`define CCC_DAYS_31 8'h31
`define CCC_DAYS_30 8'h30
`define CCC_DAYS_29 8'h29
`define CCC_DAYS_28 8'h28
`define CCC_MON_FEB 8'h02
`define CCC_MON_APR 8'h04
`define CCC_MON_JUN 8'h06
`define CCC_MON_SEP 8'h09
`define CCC_MON_NOV 8'h11

// Timing: half-second period and clock rate give the prescaler length.
`define CCC_HALF_SEC_MS 500
`define CCC_CLK_MHZ 250
`define CCC_HALF_SEC_CYCLES (`CCC_HALF_SEC_MS * 1000 * `CCC_CLK_MHZ)
`define CCC_SYNC_LEAD_CYCLES 32

// Bus responses.
`define CCC_RESP_OKAY 2'h0
`define CCC_RESP_SLVERR 2'h2

`endif

// File: src/ccc_pkg.sv
package ccc_pkg;

   typedef logic [7:0] ccc_bcd_t;

   // Full calendar state, all fields in BCD.
   typedef struct packed {
      ccc_bcd_t year;
      ccc_bcd_t month;
      ccc_bcd_t day;
      ccc_bcd_t wday;
      ccc_bcd_t hour;
      ccc_bcd_t min;
      ccc_bcd_t sec;
   } ccc_time_t;

   // Progress through the unlock key sequence.
   typedef enum logic [1:0] {
      CCC_KEY_IDLE = 2'b00,
      CCC_KEY_GOT1 = 2'b01,
      CCC_KEY_ARMED = 2'b10
   } ccc_key_t;

endpackage

// File: src/ccc_core.sv
`timescale 1ns/1ps
`include "ccc_map.svh"

module ccc_core #(
   parameter int ADDR_W = 8,
   parameter int HALF_SEC_CYCLES = `CCC_HALF_SEC_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic [ADDR_W-1:0] axi_awaddr_in,
   input wire logic axi_awvalid_in,
   output logic axi_awready_out,
   input wire logic [31:0] axi_wdata_in,
   input wire logic [3:0] axi_wstrb_in,
   input wire logic axi_wvalid_in,
   output logic axi_wready_out,
   output logic [1:0] axi_bresp_out,
   output logic axi_bvalid_out,
   input wire logic axi_bready_in,
   input wire logic [ADDR_W-1:0] axi_araddr_in,
   input wire logic axi_arvalid_in,
   output logic axi_arready_out,
   output logic [31:0] axi_rdata_out,
   output logic [1:0] axi_rresp_out,
   output logic axi_rvalid_out,
   input wire logic axi_rready_in,
   output logic irq_out
);

   localparam int CNT_W = $clog2(HALF_SEC_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_SEC_CYCLES - 1);

   if (ADDR_W < 8 || HALF_SEC_CYCLES < 2) begin : g_param_check
      $error("ccc_core: ADDR_W must be at least 8 and HALF_SEC_CYCLES at least 2.");
   end

   // Increment a BCD byte; 99 wraps to 00.
   function automatic ccc_pkg::ccc_bcd_t bcd_inc(input ccc_pkg::ccc_bcd_t v);
      if (v == `CCC_MAX_YEAR) begin
         bcd_inc = `CCC_RST_BYTE;
      end else if (v[3:0] == 4'h9) begin
         bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
      end else begin
         bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
      end
   endfunction

   // Last day of a month; a BCD year is a multiple of four when an even tens
   // digit meets 0/4/8 ones, or an odd tens digit meets 2/6 ones.
   function automatic ccc_pkg::ccc_bcd_t month_days(input ccc_pkg::ccc_bcd_t mon,
                                                    input ccc_pkg::ccc_bcd_t yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == `CCC_MON_FEB) begin
         month_days = leap ? `CCC_DAYS_29 : `CCC_DAYS_28;
      end else if (mon == `CCC_MON_APR || mon == `CCC_MON_JUN ||
                   mon == `CCC_MON_SEP || mon == `CCC_MON_NOV) begin
         month_days = `CCC_DAYS_30;
      end else begin
         month_days = `CCC_DAYS_31;
      end
   endfunction

   // Control and storage registers.
   ccc_pkg::ccc_time_t time_r;
   ccc_pkg::ccc_time_t time_nxt;
   ccc_pkg::ccc_time_t alarm_r;
   ccc_pkg::ccc_key_t key_r;
   ccc_pkg::ccc_key_t key_nxt;
   logic run_en_r, wren_r, oe_r, half_sec_r;
   logic [1:0] ptr_r, aptr_r, ptr_nxt, aptr_nxt;
   logic [5:0] alarm_cfg_hi_r;
   logic [7:0] cal_r, pad_r, repeat_r;
   logic irq_flag_r, irq_en_r, irq_prio_r, irq_r;
   logic [CNT_W-1:0] presc_r;

   // Bus channel holding registers.
   logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
   logic [7:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane0_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // Write channel: address and data are taken independently and the write
   // fires once both are held and no response is pending.
   wire aw_take = axi_awvalid_in & ~aw_full_r;
   wire w_take = axi_wvalid_in & ~w_full_r;
   wire do_wr = aw_full_r & w_full_r & ~bvalid_r;
   wire ar_take = axi_arvalid_in & ~rvalid_r;
   wire [7:0] rd_addr = axi_araddr_in[7:0];
   wire wr_ok = w_lane0_r & do_wr;

   // Address decode of the pending write.
   wire sel_cfg = aw_addr_r == `CCC_OFF_CLOCK_CONFIG;
   wire sel_vhi = aw_addr_r == `CCC_OFF_VALUE_HIGH;
   wire sel_vlo = aw_addr_r == `CCC_OFF_VALUE_LOW;
   wire sel_ahi = aw_addr_r == `CCC_OFF_ALARM_HIGH;
   wire sel_alo = aw_addr_r == `CCC_OFF_ALARM_LOW;
   wire sel_key = aw_addr_r == `CCC_OFF_UNLOCK_KEY;
   wire sel_acfg = aw_addr_r == `CCC_OFF_ALARM_CONFIG;
   wire wr_known = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r <= `CCC_OFF_IRQ_PRIO);
   wire rd_known = (rd_addr[1:0] == 2'h0) && (rd_addr <= `CCC_OFF_IRQ_PRIO);

   // Time writes pass only with write enable set.
   wire tw = wr_ok & wren_r;
   wire tw_hi = tw & sel_vhi;
   wire tw_lo = tw & sel_vlo;
   wire wr_sec = tw_lo & (ptr_r == `CCC_PTR_MINUTES_SECONDS_REG);
   wire wr_min = tw_hi & (ptr_r == `CCC_PTR_MINUTES_SECONDS_REG);
   wire wr_hour = tw_lo & (ptr_r == `CCC_PTR_WDHR);
   wire wr_wday = tw_hi & (ptr_r == `CCC_PTR_WDHR);
   wire wr_day = tw_lo & (ptr_r == `CCC_PTR_MONDAY);
   wire wr_mon = tw_hi & (ptr_r == `CCC_PTR_MONDAY);
   wire wr_year = tw_lo & (ptr_r == `CCC_PTR_YEAR);
   wire minutes_seconds_reg_wr = wr_sec | wr_min;

   // Prescaler: half-second ticks only while running; seconds on every second one.
   wire half_tick = run_en_r & (presc_r == CNT_LAST);
   wire sec_tick = half_tick & half_sec_r;

   // Carry chain through the calendar fields.
   wire [7:0] dmax = month_days(time_r.month, time_r.year);
   wire c_min = sec_tick & (time_r.sec == `CCC_MAX_SEC);
   wire c_hour = c_min & (time_r.min == `CCC_MAX_SEC);
   wire c_day = c_hour & (time_r.hour == `CCC_MAX_HOUR);
   wire c_mon = c_day & (time_r.day == dmax);
   wire c_year = c_mon & (time_r.month == `CCC_MAX_MONTH);

   // Each field takes a written byte first, else its carried value.
   wire [7:0] se_nxt = wr_sec ? w_data_r : ~sec_tick ? time_r.sec :
                       c_min ? `CCC_RST_BYTE : bcd_inc(time_r.sec);
   wire [7:0] mi_nxt = wr_min ? w_data_r : ~c_min ? time_r.min :
                       c_hour ? `CCC_RST_BYTE : bcd_inc(time_r.min);
   wire [7:0] hr_nxt = wr_hour ? w_data_r : ~c_hour ? time_r.hour :
                       c_day ? `CCC_RST_BYTE : bcd_inc(time_r.hour);
   wire [7:0] wd_nxt = wr_wday ? w_data_r : ~c_day ? time_r.wday :
                       (time_r.wday == `CCC_MAX_WDAY) ? `CCC_RST_BYTE : bcd_inc(time_r.wday);
   wire [7:0] dy_nxt = wr_day ? w_data_r : ~c_day ? time_r.day :
                       c_mon ? `CCC_RST_DAY : bcd_inc(time_r.day);
   wire [7:0] mo_nxt = wr_mon ? w_data_r : ~c_mon ? time_r.month :
                       c_year ? `CCC_RST_MONTH : bcd_inc(time_r.month);
   wire [7:0] yr_nxt = wr_year ? w_data_r : ~c_year ? time_r.year : bcd_inc(time_r.year);
   assign time_nxt = {yr_nxt, mo_nxt, dy_nxt, wd_nxt, hr_nxt, mi_nxt, se_nxt};

   // Rollover window: late in the second half, when a carry is imminent.
   wire rollover_window_flag = run_en_r & half_sec_r &
        (32'(presc_r) + `CCC_SYNC_LEAD_CYCLES >= HALF_SEC_CYCLES);

   // Unlock sequence: 55h then AAh arms; the very next write may set enable.
   wire key_write = wr_ok & sel_key;
   wire wren_set_ok = (key_r == ccc_pkg::CCC_KEY_ARMED);
   always_comb begin
      key_nxt = key_r;
      if (do_wr) begin
         unique case (key_r)
            ccc_pkg::CCC_KEY_IDLE, ccc_pkg::CCC_KEY_ARMED: begin
               key_nxt = (key_write && w_data_r == `CCC_KEY_FIRST) ?
                         ccc_pkg::CCC_KEY_GOT1 : ccc_pkg::CCC_KEY_IDLE;
            end
            ccc_pkg::CCC_KEY_GOT1: begin
               key_nxt = (key_write && w_data_r == `CCC_KEY_SECOND) ?
                         ccc_pkg::CCC_KEY_ARMED : ccc_pkg::CCC_KEY_IDLE;
            end
            default: begin
               key_nxt = ccc_pkg::CCC_KEY_IDLE;
            end
         endcase
      end
   end

   // Pointers: a config write wins, else any high-window access steps down.
   wire hi_access = (do_wr & sel_vhi) | (ar_take & rd_addr == `CCC_OFF_VALUE_HIGH);
   wire ahi_access = (do_wr & sel_ahi) | (ar_take & rd_addr == `CCC_OFF_ALARM_HIGH);
   assign ptr_nxt = (wr_ok & sel_cfg) ? w_data_r[1:0] :
                    (hi_access && ptr_r != 2'h0) ? 2'(ptr_r - 2'h1) : ptr_r;
   assign aptr_nxt = (wr_ok & sel_acfg) ? w_data_r[1:0] :
                     (ahi_access && aptr_r != 2'h0) ? 2'(aptr_r - 2'h1) : aptr_r;

   // Window contents; the high byte of the year pair is unimplemented.
   wire [7:0] vhi = (ptr_r == `CCC_PTR_YEAR) ? `CCC_RST_BYTE :
                    (ptr_r == `CCC_PTR_MONDAY) ? time_r.month :
                    (ptr_r == `CCC_PTR_WDHR) ? time_r.wday : time_r.min;
   wire [7:0] vlo = (ptr_r == `CCC_PTR_YEAR) ? time_r.year :
                    (ptr_r == `CCC_PTR_MONDAY) ? time_r.day :
                    (ptr_r == `CCC_PTR_WDHR) ? time_r.hour : time_r.sec;
   wire [7:0] ahi = (aptr_r == `CCC_PTR_YEAR) ? `CCC_RST_BYTE :
                    (aptr_r == `CCC_PTR_MONDAY) ? alarm_r.month :
                    (aptr_r == `CCC_PTR_WDHR) ? alarm_r.wday : alarm_r.min;
   wire [7:0] alo = (aptr_r == `CCC_PTR_YEAR) ? `CCC_RST_BYTE :
                    (aptr_r == `CCC_PTR_MONDAY) ? alarm_r.day :
                    (aptr_r == `CCC_PTR_WDHR) ? alarm_r.hour : alarm_r.sec;
   wire [7:0] cfg_rd = {run_en_r, 1'b0, wren_r, rollover_window_flag,
                        half_sec_r, oe_r, ptr_r};

   // Read data mux; unmapped offsets read zero.
   wire [7:0] rd_byte = (rd_addr == `CCC_OFF_CLOCK_CONFIG) ? cfg_rd :
                        (rd_addr == `CCC_OFF_CLOCK_CAL) ? cal_r :
                        (rd_addr == `CCC_OFF_PAD_CONFIG) ? pad_r :
                        (rd_addr == `CCC_OFF_ALARM_CONFIG) ? {alarm_cfg_hi_r, aptr_r} :
                        (rd_addr == `CCC_OFF_ALARM_REPEAT) ? repeat_r :
                        (rd_addr == `CCC_OFF_VALUE_HIGH) ? vhi :
                        (rd_addr == `CCC_OFF_VALUE_LOW) ? vlo :
                        (rd_addr == `CCC_OFF_ALARM_HIGH) ? ahi :
                        (rd_addr == `CCC_OFF_ALARM_LOW) ? alo :
                        (rd_addr == `CCC_OFF_IRQ_FLAGS) ? {7'h00, irq_flag_r} :
                        (rd_addr == `CCC_OFF_IRQ_ENABLES) ? {7'h00, irq_en_r} :
                        (rd_addr == `CCC_OFF_IRQ_PRIO) ? {7'h00, irq_prio_r} : 8'h00;

   // Interrupt flag: the seconds event wins over a same-cycle write-one clear.
   wire irq_clr = wr_ok & (aw_addr_r == `CCC_OFF_IRQ_FLAGS) & w_data_r[`CCC_IRQ_CAL];
   wire irq_flag_nxt = sec_tick | (irq_flag_r & ~irq_clr);

   assign axi_awready_out = ~aw_full_r;
   assign axi_wready_out = ~w_full_r;
   assign axi_arready_out = ~rvalid_r;
   assign axi_bvalid_out = bvalid_r;
   assign axi_bresp_out = bresp_r;
   assign axi_rvalid_out = rvalid_r;
   assign axi_rresp_out = rresp_r;
   assign axi_rdata_out = rdata_r;
   assign irq_out = irq_r;

   // Write channel holding and response.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         bvalid_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 8'h00;
         w_lane0_r <= 1'b0;
         bresp_r <= `CCC_RESP_OKAY;
      end else begin
         aw_full_r <= aw_take | (aw_full_r & ~do_wr);
         w_full_r <= w_take | (w_full_r & ~do_wr);
         bvalid_r <= do_wr | (bvalid_r & ~axi_bready_in);
         if (aw_take) begin
            aw_addr_r <= axi_awaddr_in[7:0];
         end
         if (w_take) begin
            w_data_r <= axi_wdata_in[7:0];
            w_lane0_r <= axi_wstrb_in[0];
         end
         if (do_wr) begin
            bresp_r <= wr_known ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
         end
      end
   end

   // Read channel: data captured at the address handshake.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `CCC_RESP_OKAY;
      end else begin
         rvalid_r <= ar_take | (rvalid_r & ~axi_rready_in);
         if (ar_take) begin
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_known ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
         end
      end
   end

   // Prescaler and half-second field; minutes/seconds writes restart the second.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         presc_r <= '0;
         half_sec_r <= 1'b0;
      end else begin
         if (minutes_seconds_reg_wr) begin
            presc_r <= '0;
         end else if (run_en_r) begin
            presc_r <= half_tick ? '0 : CNT_W'(presc_r + 1'b1);
         end
         if (minutes_seconds_reg_wr) begin
            half_sec_r <= 1'b0;
         end else if (half_tick) begin
            half_sec_r <= ~half_sec_r;
         end
      end
   end

   // Calendar, configuration and interrupt state.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         time_r <= '{`CCC_RST_BYTE, `CCC_RST_MONTH, `CCC_RST_DAY, `CCC_RST_BYTE,
                     `CCC_RST_BYTE, `CCC_RST_BYTE, `CCC_RST_BYTE};
         alarm_r <= '0;
         key_r <= ccc_pkg::CCC_KEY_IDLE;
         run_en_r <= 1'b0;
         wren_r <= 1'b0;
         oe_r <= 1'b0;
         ptr_r <= 2'h0;
         aptr_r <= 2'h0;
         alarm_cfg_hi_r <= 6'h00;
         cal_r <= `CCC_RST_BYTE;
         pad_r <= `CCC_RST_BYTE;
         repeat_r <= `CCC_RST_BYTE;
         irq_flag_r <= 1'b0;
         irq_en_r <= 1'b0;
         irq_prio_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         time_r <= time_nxt;
         key_r <= key_nxt;
         ptr_r <= ptr_nxt;
         aptr_r <= aptr_nxt;
         irq_flag_r <= irq_flag_nxt;
         irq_r <= irq_flag_r & irq_en_r;
         if (wr_ok & sel_cfg) begin
            run_en_r <= w_data_r[`CCC_CFG_RUN];
            oe_r <= w_data_r[`CCC_CFG_OE];
            wren_r <= w_data_r[`CCC_CFG_WREN] & (wren_r | wren_set_ok);
         end
         if (wr_ok & sel_acfg) begin
            alarm_cfg_hi_r <= w_data_r[7:2];
         end
         if (wr_ok & (aw_addr_r == `CCC_OFF_CLOCK_CAL)) begin
            cal_r <= w_data_r;
         end
         if (wr_ok & (aw_addr_r == `CCC_OFF_PAD_CONFIG)) begin
            pad_r <= w_data_r;
         end
         if (wr_ok & (aw_addr_r == `CCC_OFF_ALARM_REPEAT)) begin
            repeat_r <= w_data_r;
         end
         if (wr_ok & (aw_addr_r == `CCC_OFF_IRQ_ENABLES)) begin
            irq_en_r <= w_data_r[`CCC_IRQ_CAL];
         end
         if (wr_ok & (aw_addr_r == `CCC_OFF_IRQ_PRIO)) begin
            irq_prio_r <= w_data_r[`CCC_IRQ_CAL];
         end
         // Alarm pairs follow the alarm pointer; alarm values are not locked.
         if (wr_ok & sel_ahi & (aptr_r == `CCC_PTR_MINUTES_SECONDS_REG)) alarm_r.min <= w_data_r;
         if (wr_ok & sel_alo & (aptr_r == `CCC_PTR_MINUTES_SECONDS_REG)) alarm_r.sec <= w_data_r;
         if (wr_ok & sel_ahi & (aptr_r == `CCC_PTR_WDHR)) alarm_r.wday <= w_data_r;
         if (wr_ok & sel_alo & (aptr_r == `CCC_PTR_WDHR)) alarm_r.hour <= w_data_r;
         if (wr_ok & sel_ahi & (aptr_r == `CCC_PTR_MONDAY)) alarm_r.month <= w_data_r;
         if (wr_ok & sel_alo & (aptr_r == `CCC_PTR_MONDAY)) alarm_r.day <= w_data_r;
      end
   end

   // Locked writes leave the seconds byte alone.
   lock_write_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (do_wr && sel_vlo && !wren_r && !sec_tick) |=> time_r.sec == $past(time_r.sec))
      else $error("Seconds changed by a locked write.");
   ptr_step_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (hi_access && !(wr_ok && sel_cfg) && ptr_r != 2'h0) |=> ptr_r == $past(ptr_r) - 2'h1)
      else $error("Value pointer did not step down.");
   ptr_floor_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (hi_access && !(wr_ok && sel_cfg) && ptr_r == 2'h0) |=> ptr_r == 2'h0)
      else $error("Value pointer went below zero.");
   presc_clear_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      minutes_seconds_reg_wr |=> (presc_r == '0 && !half_sec_r))
      else $error("Prescalers not cleared by minutes/seconds write.");
   run_gate_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (!run_en_r && !tw) |=> (time_r == $past(time_r) && presc_r == $past(presc_r)))
      else $error("Calendar moved while stopped.");
   month_roll_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (c_day && time_r.day == dmax && !wr_day) |=> time_r.day == `CCC_RST_DAY)
      else $error("Day did not roll to the first of the month.");
   leap_feb_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (c_day && !wr_day && time_r.month == `CCC_MON_FEB && time_r.day == `CCC_DAYS_28 &&
       time_r.year[1:0] == 2'h0 && !time_r.year[4]) |=> time_r.day == `CCC_DAYS_29)
      else $error("Leap February skipped day 29.");
   unlock_gate_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (!wren_r && key_r != ccc_pkg::CCC_KEY_ARMED) |=> !wren_r)
      else $error("Write enable set without the key sequence.");
   irq_flag_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      sec_tick |=> irq_flag_r ##1 (irq_r == irq_en_r || $past(irq_en_r) != irq_en_r))
      else $error("Calendar event did not raise its flag.");
   sync_flag_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      sec_tick |-> cfg_rd[`CCC_CFG_SYNC])
      else $error("Rollover flag clear at a carry.");

endmodule

// File: tb/test_calendar_clock_core.sv
`timescale 1ns/1ps
`include "ccc_map.svh"

module test_calendar_clock_core;
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] aw = 8'h00;
   logic [7:0] ar = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0, wv = 1'b0, arv = 1'b0, rre = 1'b1;
   logic awr, wrdy, bv, arr, rv, irq;
   logic [1:0] br, rr;
   logic [31:0] rdat;
   logic [33:0] exp_q[$];
   logic [1:0] bq[$];
   logic [7:0] tv;
   // Start dates: leap and plain February ends, a 30-day month, and a leap 28th.
   logic [7:0] cy[4] = '{8'h24, 8'h23, 8'h23, 8'h24};
   logic [7:0] cm[4] = '{8'h02, 8'h02, 8'h04, 8'h02};
   logic [7:0] cd[4] = '{8'h29, 8'h28, 8'h30, 8'h28};
   logic [7:0] nm[4] = '{8'h03, 8'h03, 8'h05, 8'h02};
   logic [7:0] nd[4] = '{8'h01, 8'h01, 8'h01, 8'h29};
   int err_count = 0, checked = 0, cyc = 0, seed = 32'h07646D90;
   localparam logic [7:0] cfg = `CCC_OFF_CLOCK_CONFIG;
   localparam logic [7:0] vlo = `CCC_OFF_VALUE_LOW;
   localparam logic [7:0] vhi = `CCC_OFF_VALUE_HIGH;
   localparam logic [7:0] flg = `CCC_OFF_IRQ_FLAGS;
   localparam logic [1:0] ok = `CCC_RESP_OKAY;

   // The half second is shortened so a full second costs only 80 cycles.
   always #2 ref_clk_in = ~ref_clk_in;
   ccc_core #(.HALF_SEC_CYCLES(40)) i_ccc_core (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .axi_awaddr_in(aw), .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_wdata_in(wd),
      .axi_wstrb_in(4'hF), .axi_wvalid_in(wv), .axi_wready_out(wrdy), .axi_bresp_out(br),
      .axi_bvalid_out(bv), .axi_bready_in(1'b1), .axi_araddr_in(ar), .axi_arvalid_in(arv),
      .axi_arready_out(arr), .axi_rdata_out(rdat), .axi_rresp_out(rr), .axi_rvalid_out(rv),
      .axi_rready_in(rre), .irq_out(irq));

   task chk(input string n, input logic [33:0] e, input logic [33:0] s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task wrap_up;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Handshakes are judged at the rising edge; the response is noted for the monitor.
   task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = `CCC_RESP_OKAY);
      logic ta, tw, h;
      h = 1'b0;
      bq.push_back(er);
      aw <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      while (!h) begin
         @(posedge ref_clk_in);
         ta = awv && awr;
         tw = wv && wrdy;
         h = bv;
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
   endtask

   // Reads note their expectation; the monitor below compares the answer.
   task rd(input logic [7:0] a, input logic [1:0] er, input logic [7:0] ed);
      logic t, h;
      h = 1'b0;
      exp_q.push_back({er, 24'h0, ed});
      ar <= a;
      arv <= 1'b1;
      while (!h) begin
         @(posedge ref_clk_in);
         t = arv && arr;
         h = rv;
         if (t) arv <= 1'b0;
      end
   endtask

   // Read and write answers are matched against the oldest noted expectation.
   always @(posedge ref_clk_in) begin
      cyc++;
      if (rv && rre) chk("read", exp_q.pop_front(), {rr, rdat});
      if (bv) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
      if (cyc > 8000) begin
         err_count++;
         wrap_up;
      end
   end

   // Each case sets the last second of its start date, runs one second, then reads all pairs back.
   initial begin
      repeat (10) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      rd(cfg, ok, 8'h00);
      rd(`CCC_OFF_UNLOCK_KEY, ok, 8'h00);
      rd(8'h40, `CCC_RESP_SLVERR, 8'h00);
      wr(8'h40, 8'h00, `CCC_RESP_SLVERR);
      wr(vlo, 8'h30);
      rd(vlo, ok, 8'h00);
      wr(cfg, 8'h20);
      rd(cfg, ok, 8'h00);
      tv = 8'($random(seed));
      wr(`CCC_OFF_CLOCK_CAL, tv);
      rd(`CCC_OFF_CLOCK_CAL, ok, tv);
      // Alarm pairs: the high write steps the alarm pointer down to min/sec.
      wr(`CCC_OFF_ALARM_CONFIG, 8'h01);
      wr(`CCC_OFF_ALARM_HIGH, 8'h05);
      wr(`CCC_OFF_ALARM_LOW, 8'h42);
      wr(`CCC_OFF_ALARM_CONFIG, 8'h01);
      rd(`CCC_OFF_ALARM_CONFIG, ok, 8'h01);
      rd(`CCC_OFF_ALARM_HIGH, ok, 8'h05);
      rd(`CCC_OFF_ALARM_LOW, ok, 8'h42);
      for (int i = 0; i < 4; i++) begin
         wr(cfg, 8'h00);
         wr(`CCC_OFF_UNLOCK_KEY, `CCC_KEY_FIRST);
         wr(`CCC_OFF_UNLOCK_KEY, `CCC_KEY_SECOND);
         wr(cfg, 8'h63);
         wr(vlo, cy[i]);
         wr(vhi, 8'h00);
         wr(vlo, cd[i]);
         wr(vhi, cm[i]);
         wr(vlo, 8'h23);
         wr(vhi, 8'h03);
         wr(vlo, 8'h59);
         wr(vhi, 8'h59);
         rd(cfg, ok, 8'h20);
         wr(cfg, 8'h83);
         repeat (100) @(posedge ref_clk_in);
         rd(vlo, ok, cy[i]);
         rd(vlo, ok, cy[i]);
         rd(vhi, ok, 8'h00);
         rd(vlo, ok, nd[i]);
         rd(vhi, ok, nm[i]);
         rd(vlo, ok, 8'h00);
         rd(vhi, ok, 8'h04);
         rd(vlo, ok, 8'h00);
         rd(vhi, ok, 8'h00);
      end
      wr(cfg, 8'h00);
      rd(flg, ok, 8'h01);
      chk("irq", 34'h0, {33'h0, irq});
      wr(`CCC_OFF_IRQ_ENABLES, 8'h01);
      repeat (2) @(posedge ref_clk_in);
      chk("irq", 34'h1, {33'h0, irq});
      wr(flg, 8'h01);
      repeat (2) @(posedge ref_clk_in);
      chk("irq", 34'h0, {33'h0, irq});
      rd(flg, ok, 8'h00);
      wrap_up;
   end
endmodule
